// file: shared/port_pin_data_pkg.sv
// port b package: register map, reset values, field positions
// assumes apb with 32-bit data; printed offsets are not all multiples of four, so byte address = 4 * index
package port_pin_data_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PINS = 8;
  // register indices as printed
  localparam logic [ADDR_W-1:0] IDX_PORT_PIN_DATA = 12'h006;
  localparam logic [ADDR_W-1:0] IDX_OPTION_CONTROL = 12'h081;
  localparam logic [ADDR_W-1:0] IDX_PORT_DIRECTION = 12'h086;
  localparam logic [ADDR_W-1:0] IDX_PULLUP_ENABLE = 12'h095;
  localparam logic [ADDR_W-1:0] IDX_CHANGE_DETECT_ENABLE = 12'h096;
  localparam logic [ADDR_W-1:0] IDX_ANALOG_SELECT = 12'h09d;
  // block-local registers
  localparam logic [ADDR_W-1:0] IDX_IRQ_CONTROL = 12'h0a0;
  localparam logic [ADDR_W-1:0] IDX_PERIPH_CONTROL = 12'h0a1;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h0a2;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h0a3;
  localparam int unsigned IDX_SHIFT = 2;
  // reset values
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PULLUP = 8'hff;
  localparam logic [7:0] RST_CHANGE = 8'hf0;
  localparam logic [7:0] RST_ANALOG = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h01;
  // field positions
  localparam int unsigned OPT_PULLUP_DIS = 7;
  localparam int unsigned IRQ_FLAG = 0;
  localparam int unsigned IRQ_PORT_EN = 3;
  localparam int unsigned IRQ_GLOBAL_EN = 7;
  localparam int unsigned ANS_PIN0 = 4;
  localparam int unsigned ANS_PIN1 = 5;
  localparam int unsigned PER_OSC_EN = 0;
  localparam int unsigned PER_SEL_LO = 1;
  localparam int unsigned PER_SEL_HI = 2;
  localparam int unsigned STAT_CHANGE = 0;
  // pin numbers
  localparam int unsigned PIN_CLK = 2;
  localparam int unsigned PIN_CCP = 3;
  localparam int unsigned PIN_SDA = 4;
  localparam int unsigned PIN_OSC = 6;
  // pin 2/3/4 function selects
  typedef enum logic [1:0] {
    FN_PORT = 2'b00,
    FN_PUSH = 2'b01,
    FN_OPEN = 2'b11,
    FN_ALT = 2'b10
  } pin_fn_t;
endpackage : port_pin_data_pkg

// file: src/apb_reg_slave.sv
// apb slave front end: decodes word index and produces one-cycle strobes
// assumes an apb master with 32-bit data; answers in the access cycle, no wait states
`timescale 1ns/1ps
`default_nettype none
module apb_reg_slave (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [port_pin_data_pkg::ADDR_W+1:0] paddr_i,
  output logic pready_o,
  output logic access_o,
  output logic write_o,
  output logic [port_pin_data_pkg::ADDR_W-1:0] index_o
);
  import port_pin_data_pkg::*;
  assign pready_o = 1'b1;
  assign access_o = psel_i & penable_i;
  assign write_o = psel_i & penable_i & pwrite_i;
  assign index_o = paddr_i[ADDR_W+1:IDX_SHIFT];
endmodule : apb_reg_slave
`default_nettype wire

// file: src/change_detect.sv
// change detector: compares monitored inputs with the snapshot from the last port access, read or write
// assumes pin inputs synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module change_detect (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] enable_i,
  input wire logic snap_i,
  output logic mismatch_o
);
  import port_pin_data_pkg::*;
  logic [7:0] snap_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      snap_q <= RST_ZERO;
    end else if (snap_i) begin
      snap_q <= pin_i;
    end
  end
  assign mismatch_o = |((pin_i ^ snap_q) & enable_i); // RL14
endmodule : change_detect
`default_nettype wire

// file: src/port_b_pullup_change_detect.sv
// eight-bit port with pull-ups, change detect, analog select and pin sharing
// assumes apb master, pins synchronous to clk_i, peripherals supplied as plain signals
//
// Summary of operation
// RL1: eight read/write pull-up enables, all one after reset.
// RL2: a per-pin change-detect enable, one enables detection on that pin; here only on pins whose direction bit is one.
// RL3: change-detect enables reset to upper four ones, lower four zeros.
// RL4: change interrupt only when global and port-change enables are both set.
// RL5: pin 0 shared with analog input 4 and external interrupt input.
// RL6: pin 1 shared with analog input 5 and serial slave-select input.
// RL7: pins 1 and 0 analog after reset, digital reads give zero.
// RL8: secondary oscillator enable overrides port and pwm c on pin 6.
// RL9: pin 3 serves capture input, compare output or pwm a.
// RL10: pin 2 carries spi clock push-pull or i2c clock open-drain.
// RL11: pin 4 serves spi data input or i2c data open-drain.
// RL12: pull-ups act only while global pull-up disable is clear.
// RL13: pull-up switched off whenever the pin is an output.
// RL14: monitored inputs compared to last-read value, or of mismatches sets flag; here the value is also taken on port writes.
// RL15: while mismatch persists the flag keeps setting; port access ends it.
// RL16: direction one floats the driver, zero drives the output latch.
`timescale 1ns/1ps
`default_nettype none
module port_b_pullup_change_detect (
  input wire logic clk_i,
  input wire logic reset_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [port_pin_data_pkg::ADDR_W+1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_n_o,
  output logic [7:0] pullup_on_o,
  // pin sharing
  output logic analog_in4_o,
  output logic analog_in5_o,
  output logic ext_irq_o,
  output logic slave_select_o,
  input wire logic serial_clk_out_i,
  output logic serial_clk_in_o,
  input wire logic capture_compare_out_i,
  input wire logic capture_compare_oe_i,
  input wire logic pwm_out_a_i,
  output logic capture_compare_pin_o,
  output logic serial_data_in_o,
  input wire logic serial_data_out_i,
  output logic osc_enable_o,
  // interrupt
  output logic port_change_flag_o,
  output logic irq_o
);
  import port_pin_data_pkg::*;

  // ----------------------------------------
  // registers and bus
  // ----------------------------------------
  logic [7:0] latch_q;
  logic [7:0] option_q;
  logic [7:0] dir_q;
  logic [7:0] pullup_q;
  logic [7:0] change_en_q;
  logic [7:0] analog_q;
  logic [7:0] irq_ctl_q;
  logic [7:0] periph_q;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [7:0] pin_read;
  logic [7:0] drive_d;
  logic [7:0] oe_n_d;
  logic access;
  logic setup;
  logic wr;
  logic [ADDR_W-1:0] idx;
  logic mapped;
  logic port_setup;
  logic status_read;
  logic mismatch;
  logic flag_wr;
  pin_fn_t fn_clk;
  pin_fn_t fn_ccp;
  pin_fn_t fn_sda;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] i);
    if (i == IDX_PORT_PIN_DATA) begin
      return 1'b1;
    end else if (i == IDX_OPTION_CONTROL) begin
      return 1'b1;
    end else if (i == IDX_PORT_DIRECTION) begin
      return 1'b1;
    end else if (i == IDX_PULLUP_ENABLE) begin
      return 1'b1;
    end else if (i == IDX_CHANGE_DETECT_ENABLE) begin
      return 1'b1;
    end else if (i == IDX_ANALOG_SELECT) begin
      return 1'b1;
    end else if (i == IDX_IRQ_CONTROL || i == IDX_PERIPH_CONTROL) begin
      return 1'b1;
    end else if (i == IDX_IRQ_STATUS || i == IDX_IRQ_MASK) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : is_mapped

  // two-bit function field of a shared pin, pins 2 to 4 in ascending field order
  function automatic pin_fn_t fn_field(input logic [7:0] p, input int unsigned pin);
    return pin_fn_t'(p[PER_SEL_LO + $bits(pin_fn_t) * (pin - PIN_CLK) +: $bits(pin_fn_t)]);
  endfunction : fn_field

  apb_reg_slave u_bus (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pready_o(pready_o),
    .access_o(access),
    .write_o(wr),
    .index_o(idx)
  );

  assign mapped = is_mapped(idx);
  assign pslverr_o = access & ~mapped;
  assign setup = psel_i & ~penable_i;
  // the snapshot is taken with the read data, so the compare uses what software saw
  assign port_setup = setup & (idx == IDX_PORT_PIN_DATA);
  assign status_read = access & ~pwrite_i & (idx == IDX_IRQ_STATUS);
  assign flag_wr = wr & (idx == IDX_IRQ_CONTROL);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      latch_q <= RST_ZERO;
    end else if (wr && idx == IDX_PORT_PIN_DATA) begin
      latch_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      option_q <= RST_OPTION;
      dir_q <= RST_DIRECTION;
      pullup_q <= RST_PULLUP; // RL1
      change_en_q <= RST_CHANGE; // RL3
      analog_q <= RST_ANALOG; // RL7
      periph_q <= RST_ZERO;
      mask_q <= RST_MASK;
    end else if (wr) begin
      if (idx == IDX_OPTION_CONTROL) begin
        option_q <= pwdata_i[7:0];
      end else if (idx == IDX_PORT_DIRECTION) begin
        dir_q <= pwdata_i[7:0];
      end else if (idx == IDX_PULLUP_ENABLE) begin
        pullup_q <= pwdata_i[7:0]; // RL1
      end else if (idx == IDX_CHANGE_DETECT_ENABLE) begin
        change_en_q <= pwdata_i[7:0]; // RL2
      end else if (idx == IDX_ANALOG_SELECT) begin
        analog_q <= pwdata_i[7:0];
      end else if (idx == IDX_PERIPH_CONTROL) begin
        periph_q <= pwdata_i[7:0];
      end else if (idx == IDX_IRQ_MASK) begin
        mask_q <= pwdata_i[7:0];
      end
    end
  end

  // ----------------------------------------
  // change detection and flags
  // ----------------------------------------
  // only pins whose direction bit is one are compared; pins with direction zero never raise a change
  change_detect u_change (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(pin_read),
    .enable_i(change_en_q & dir_q), // RL2
    .snap_i(port_setup),
    .mismatch_o(mismatch)
  );

  // a live mismatch sets the flag even in the cycle software clears it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_ctl_q <= RST_ZERO;
    end else begin
      if (flag_wr) begin
        irq_ctl_q <= pwdata_i[7:0];
      end
      if (mismatch) begin
        irq_ctl_q[IRQ_FLAG] <= 1'b1; // RL15
      end
    end
  end

  // sticky status, cleared by reading it; a new event wins over the clear
  // only bits returned to software are cleared, so an event after the setup cycle is kept
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_q <= RST_ZERO;
    end else begin
      if (status_read) begin
        status_q <= status_q & ~rdata_q;
      end
      if (mismatch) begin
        status_q[STAT_CHANGE] <= 1'b1; // RL14
      end
    end
  end

  assign port_change_flag_o = irq_ctl_q[IRQ_FLAG];
  // level interrupt: both enables and an unmasked status bit
  assign irq_o = irq_ctl_q[IRQ_GLOBAL_EN] & irq_ctl_q[IRQ_PORT_EN] & |(status_q & mask_q); // RL4

  // ----------------------------------------
  // pin input path
  // ----------------------------------------
  always_comb begin
    pin_read = pin_i;
    pin_read[0] = pin_i[0] & ~analog_q[ANS_PIN0]; // RL7
    pin_read[1] = pin_i[1] & ~analog_q[ANS_PIN1]; // RL7
  end

  assign analog_in4_o = analog_q[ANS_PIN0] & pin_i[0]; // RL5
  assign analog_in5_o = analog_q[ANS_PIN1] & pin_i[1]; // RL6
  assign ext_irq_o = pin_read[0]; // RL5
  assign slave_select_o = pin_read[1]; // RL6
  assign serial_clk_in_o = pin_i[PIN_CLK]; // RL10
  assign serial_data_in_o = pin_i[PIN_SDA]; // RL11
  assign capture_compare_pin_o = pin_i[PIN_CCP]; // RL9
  assign osc_enable_o = periph_q[PER_OSC_EN]; // RL8

  // ----------------------------------------
  // pin output path
  // ----------------------------------------
  assign fn_clk = fn_field(periph_q, PIN_CLK);
  assign fn_ccp = fn_field(periph_q, PIN_CCP);
  assign fn_sda = fn_field(periph_q, PIN_SDA);

  always_comb begin
    drive_d = latch_q;
    oe_n_d = dir_q; // RL16
    case (fn_clk)
      FN_PUSH: begin
        drive_d[PIN_CLK] = serial_clk_out_i; // RL10
      end
      FN_OPEN: begin
        drive_d[PIN_CLK] = 1'b0;
        oe_n_d[PIN_CLK] = serial_clk_out_i; // RL10
      end
      default: begin
      end
    endcase
    case (fn_ccp)
      FN_PUSH: begin
        drive_d[PIN_CCP] = capture_compare_out_i; // RL9
        oe_n_d[PIN_CCP] = ~capture_compare_oe_i;
      end
      FN_ALT: begin
        drive_d[PIN_CCP] = pwm_out_a_i; // RL9
        oe_n_d[PIN_CCP] = 1'b0;
      end
      default: begin
      end
    endcase
    case (fn_sda)
      FN_OPEN: begin
        drive_d[PIN_SDA] = 1'b0;
        oe_n_d[PIN_SDA] = serial_data_out_i; // RL11
      end
      FN_PUSH: begin
        oe_n_d[PIN_SDA] = 1'b1; // RL11
      end
      default: begin
      end
    endcase
    if (periph_q[PER_OSC_EN]) begin
      oe_n_d[PIN_OSC] = 1'b1; // RL8
      drive_d[PIN_OSC] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_o <= RST_ZERO;
      pin_oe_n_o <= RST_DIRECTION;
      pullup_on_o <= RST_ZERO;
    end else begin
      pin_o <= drive_d;
      pin_oe_n_o <= oe_n_d; // RL16
      pullup_on_o <= pullup_q & oe_n_d & {PINS{~option_q[OPT_PULLUP_DIS]}}; // RL12 RL13
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    if (idx == IDX_PORT_PIN_DATA) begin
      rdata_d = pin_read;
    end else if (idx == IDX_OPTION_CONTROL) begin
      rdata_d = option_q;
    end else if (idx == IDX_PORT_DIRECTION) begin
      rdata_d = dir_q;
    end else if (idx == IDX_PULLUP_ENABLE) begin
      rdata_d = pullup_q;
    end else if (idx == IDX_CHANGE_DETECT_ENABLE) begin
      rdata_d = change_en_q;
    end else if (idx == IDX_ANALOG_SELECT) begin
      rdata_d = analog_q;
    end else if (idx == IDX_IRQ_CONTROL) begin
      rdata_d = irq_ctl_q;
    end else if (idx == IDX_PERIPH_CONTROL) begin
      rdata_d = periph_q;
    end else if (idx == IDX_IRQ_STATUS) begin
      rdata_d = status_q;
    end else if (idx == IDX_IRQ_MASK) begin
      rdata_d = mask_q;
    end else begin
      rdata_d = RST_ZERO;
    end
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  // loaded in the setup cycle, so it stands through the whole access phase
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= RST_ZERO;
    end else if (setup) begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata_o = {24'h00_0000, rdata_q};
endmodule : port_b_pullup_change_detect
`default_nettype wire

// file: tb/pin_partner.sv
// external circuits on the eight pins
// assumes design drive wins; a pin nobody drives or pulls toggles each cycle
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic clk_i,
  input wire logic [7:0] drive_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pull_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] level_o
);
  logic [7:0] alt_q = 8'h55;
  always_ff @(posedge clk_i) begin
    alt_q <= ~alt_q;
  end
  assign level_o = (~oe_n_i & drive_i) | (oe_n_i & ext_en_i & ext_val_i) | (oe_n_i & ~ext_en_i & (pull_i | alt_q));
endmodule : pin_partner
`default_nettype wire

// file: tb/port_b_props.sv
// checker for the port block, sees only its top ports
// assumes one clock domain, reset synchronous and active high
`timescale 1ns/1ps
`default_nettype none
module port_b_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [port_pin_data_pkg::ADDR_W+1:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic [7:0] pullup_on_o,
  input wire logic analog_in4_o,
  input wire logic analog_in5_o,
  input wire logic ext_irq_o,
  input wire logic slave_select_o,
  input wire logic serial_clk_in_o,
  input wire logic serial_data_in_o,
  input wire logic capture_compare_pin_o,
  input wire logic osc_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence acc_s;
    psel_i && penable_i;
  endsequence
  sequence bad_s;
    psel_i && penable_i && paddr_i[13:2] == 12'h0ff;
  endsequence
  sequence osc_held_s;
    osc_enable_o ##1 osc_enable_o;
  endsequence
  a_ready_high: assert property (acc_s |-> pready_o && prdata_o[31:8] == 24'h00_0000)
    else $error("access not answered cleanly");
  a_err_in_access: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access");
  a_unmapped_err: assert property (bad_s |-> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_reset_pins: assert property ($past(reset_i) |-> pin_oe_n_o == 8'hff && pullup_on_o == 8'h00)
    else $error("pins not idle after reset");
  a_pullup_output: assert property ((pullup_on_o & ~pin_oe_n_o) == 8'h00)
    else $error("pull-up on a driven pin");
  a_ext_irq_pin: assert property (ext_irq_o |-> pin_i[0] && !analog_in4_o)
    else $error("interrupt input wrong");
  a_slave_sel_pin: assert property (slave_select_o |-> pin_i[1] && !analog_in5_o)
    else $error("slave select wrong");
  a_shared_inputs: assert property (serial_clk_in_o == pin_i[2] && serial_data_in_o == pin_i[4] && capture_compare_pin_o == pin_i[3])
    else $error("shared input level wrong");
  a_osc_float: assert property (osc_held_s |-> pin_oe_n_o[6] && !pin_o[6])
    else $error("oscillator pin driven");
endmodule : port_b_props
bind port_b_pullup_change_detect port_b_props chk (.clk_i, .reset_i, .psel_i, .penable_i, .paddr_i, .prdata_o,
  .pready_o, .pslverr_o, .pin_i, .pin_o, .pin_oe_n_o, .pullup_on_o, .analog_in4_o, .analog_in5_o, .ext_irq_o,
  .slave_select_o, .serial_clk_in_o, .serial_data_in_o, .capture_compare_pin_o, .osc_enable_o);
`default_nettype wire

// file: tb/port_b_pullup_change_detect_tb.sv
// self-checking bench: apb traffic, pin levels, change interrupt, pin sharing
// assumes pin_partner resolves every pin
`timescale 1ns/1ps
`default_nettype none
module port_b_pullup_change_detect_tb;
  import port_pin_data_pkg::*;
  logic clk_i = 0, reset_i = 1, psel = 0, pen = 0, pwr = 0, pready, perr, er;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] pin_i, pin_o, oe_n, pull, v, ext_en = 8'hff, ext_val = 8'h00;
  logic a4, a5, eirq, ss, sck_in, sdi, ccp, osc, flag, irq;
  logic sck = 0, sdo = 0, cco = 0, ccoe = 0, pwma = 0;
  logic [16:0] seed = 17'h1_5465;
  int fails = 0, total_checks = 0;
  logic [11:0] rix [6] = '{IDX_PULLUP_ENABLE, IDX_CHANGE_DETECT_ENABLE, IDX_ANALOG_SELECT,
    IDX_PORT_DIRECTION, IDX_OPTION_CONTROL, IDX_IRQ_MASK};
  logic [7:0] rval [6] = '{8'hff, 8'hf0, 8'hff, 8'hff, 8'hff, 8'h01};
  always #2.5 clk_i = ~clk_i;
  port_b_pullup_change_detect dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .pullup_on_o(pull), .analog_in4_o(a4), .analog_in5_o(a5),
    .ext_irq_o(eirq), .slave_select_o(ss), .serial_clk_out_i(sck), .serial_clk_in_o(sck_in),
    .capture_compare_out_i(cco), .capture_compare_oe_i(ccoe), .pwm_out_a_i(pwma), .capture_compare_pin_o(ccp),
    .serial_data_in_o(sdi), .serial_data_out_i(sdo), .osc_enable_o(osc), .port_change_flag_o(flag), .irq_o(irq));
  pin_partner far (.clk_i(clk_i), .drive_i(pin_o), .oe_n_i(oe_n), .pull_i(pull), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(pin_i));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  function automatic logic [7:0] pull_exp(input logic [7:0] en, input logic [7:0] dir, input logic [7:0] opt);
    return en & dir & {PINS{~opt[OPT_PULLUP_DIS]}};
  endfunction : pull_exp
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] ix, input logic [7:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk_i);
    pen <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (rix[i]) begin
      apb(1'b0, rix[i], 8'h00);
      chk("reset value", rd, {24'h00_0000, rval[i]});
    end
    chk("pullup after reset", pull, 8'h00);
    apb(1'b0, 12'h0ff, 8'h00);
    chk("unmapped error", er, 1'b1);
    chk("unmapped data", rd, 32'h0000_0000);
    ext_val <= 8'h03;
    settle();
    apb(1'b0, IDX_PORT_PIN_DATA, 8'h00);
    chk("analog pin read", rd[1:0], 2'b00);
    chk("analog in4", a4, 1'b1);
    chk("analog in5", a5, 1'b1);
    chk("ext irq when analog", eirq, 1'b0);
    apb(1'b1, IDX_ANALOG_SELECT, 8'h00);
    seed = lfsr(seed);
    v = seed[7:0];
    ext_val <= v;
    settle();
    apb(1'b0, IDX_PORT_PIN_DATA, 8'h00);
    chk("digital read", rd, {24'h00_0000, v});
    chk("ext irq", eirq, v[0]);
    chk("slave select", ss, v[1]);
    seed = lfsr(seed);
    apb(1'b1, IDX_PULLUP_ENABLE, seed[7:0]);
    settle();
    chk("pullup global off", pull, pull_exp(seed[7:0], 8'hff, 8'hff));
    apb(1'b1, IDX_OPTION_CONTROL, 8'h7f);
    settle();
    chk("pullup on", pull, pull_exp(seed[7:0], 8'hff, 8'h7f));
    apb(1'b1, IDX_PULLUP_ENABLE, 8'hff);
    ext_en <= 8'h7f;
    settle();
    apb(1'b0, IDX_PORT_PIN_DATA, 8'h00);
    chk("pulled pin", rd[7], 1'b1);
    ext_en <= 8'hff;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'h00 : seed[7:0];
      apb(1'b1, IDX_PORT_DIRECTION, v);
      apb(1'b1, IDX_PORT_PIN_DATA, seed[15:8]);
      settle();
      chk("pullup vs direction", pull, pull_exp(8'hff, v, 8'h7f));
      chk("driver enable", oe_n, v);
      chk("drive value", pin_o & ~v, seed[15:8] & ~v);
    end
    apb(1'b1, IDX_PORT_DIRECTION, 8'hff);
    ext_val <= 8'h00;
    apb(1'b1, IDX_CHANGE_DETECT_ENABLE, 8'h01);
    apb(1'b0, IDX_PORT_PIN_DATA, 8'h00);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    apb(1'b1, IDX_IRQ_CONTROL, 8'h88);
    ext_val <= 8'h10;
    settle();
    chk("flag disabled pin", flag, 1'b0);
    ext_val <= 8'h11;
    settle();
    chk("flag", flag, 1'b1);
    chk("irq", irq, 1'b1);
    apb(1'b1, IDX_IRQ_CONTROL, 8'h88);
    settle();
    chk("flag held", flag, 1'b1);
    apb(1'b1, IDX_IRQ_CONTROL, 8'h08);
    settle();
    chk("irq global off", irq, 1'b0);
    apb(1'b1, IDX_IRQ_MASK, 8'h00);
    apb(1'b1, IDX_IRQ_CONTROL, 8'h88);
    settle();
    chk("irq masked", irq, 1'b0);
    apb(1'b1, IDX_IRQ_MASK, 8'h01);
    apb(1'b0, IDX_PORT_PIN_DATA, 8'h00);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk("status set", rd[0], 1'b1);
    apb(1'b1, IDX_IRQ_CONTROL, 8'h88);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk("status cleared", rd[0], 1'b0);
    settle();
    chk("flag cleared", flag, 1'b0);
    chk("irq cleared", irq, 1'b0);
    @(posedge clk_i);
    sdo <= 1'b1;
    pwma <= 1'b1;
    apb(1'b1, IDX_PERIPH_CONTROL, 8'h77);
    settle();
    chk("osc enable", osc, 1'b1);
    chk("osc pin float", oe_n[6], 1'b1);
    chk("open clock low", {pin_o[2], oe_n[2]}, 2'b00);
    chk("open data float", oe_n[4], 1'b1);
    chk("pwm a", pin_o[3], 1'b1);
    @(posedge clk_i);
    sck <= 1'b1;
    sdo <= 1'b0;
    cco <= 1'b1;
    ccoe <= 1'b1;
    apb(1'b1, IDX_PERIPH_CONTROL, 8'h2a);
    settle();
    chk("osc off", osc, 1'b0);
    chk("push clock", pin_o[2], 1'b1);
    chk("compare out", {pin_o[3], oe_n[3]}, 2'b10);
    chk("spi data float", oe_n[4], 1'b1);
    @(posedge clk_i);
    reset_i <= 1'b1;
    settle();
    @(posedge clk_i);
    reset_i <= 1'b0;
    settle();
    chk("oe after reset", oe_n, 8'hff);
    apb(1'b0, IDX_CHANGE_DETECT_ENABLE, 8'h00);
    chk("change enable after reset", rd, 32'h0000_00f0);
    finish_test();
  end
endmodule : port_b_pullup_change_detect_tb
`default_nettype wire
